// *** rtl/pdafr_adc_filter.sv ***
// Per-channel smoothing and hysteresis of auxiliary converter samples
`timescale 1ns/1ps
module pdafr_adc_filter
    import pdafr_pkg::*;
#(
    parameter int CHANNELS = 4
)
(
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic [9:0] sample_i,
    input wire logic [1:0] chan_i,
    input wire logic valid_i,
    pdafr_cfg_if.flt cfg
);

    // Mode field of a channel; channel 0 sits highest
    function automatic pdafr_filt_mode_t chan_mode(input logic [15:0] r,
                                                   input logic [1:0] ch);
        logic [15:0] sh;
        sh = r >> (PDAFR_CH0_MODE_LSB - PDAFR_MODE_W * int'(ch));
        return pdafr_filt_mode_t'(sh[1:0]);
    endfunction

    // True when two values differ by more than the dead band
    function automatic logic beyond(input logic [9:0] a,
                                    input logic [9:0] b,
                                    input logic [9:0] band);
        logic [9:0] diff;
        diff = (a > b) ? a - b : b - a;
        return diff > band;
    endfunction

    logic [11:0] acc_q [CHANNELS];
    logic [9:0] out_q [CHANNELS];
    logic [11:0] acc_d;
    logic [9:0] avg;
    logic [9:0] out_d;
    pdafr_filt_mode_t mode;

    // Leaky average held at four times scale; the extra bits keep
    // small steps from being truncated away
    always_comb begin
        acc_d = acc_q[chan_i] - {2'b00, acc_q[chan_i][11:2]}
                + {2'b00, sample_i};
        avg = acc_d[11:2];
        mode = chan_mode(cfg.filt_mode, chan_i);
        out_d = out_q[chan_i];
        case (mode)
            PDAFR_FILT_BYPASS: out_d = sample_i;
            PDAFR_FILT_ON: out_d = avg;
            PDAFR_FILT_HYST1: begin
                if (beyond(avg, out_q[chan_i], PDAFR_HYST1_LSB)) begin
                    out_d = avg;
                end
            end
            PDAFR_FILT_HYST2: begin
                if (beyond(avg, out_q[chan_i], PDAFR_HYST2_LSB)) begin
                    out_d = avg;
                end
            end
            default: out_d = sample_i;
        endcase
    end

    // Averager keeps running in bypass so a mode change starts settled
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < CHANNELS; i++) begin
                acc_q[i] <= '0;
                out_q[i] <= '0;
            end
        end else if (valid_i) begin
            acc_q[chan_i] <= acc_d;
            out_q[chan_i] <= out_d;
        end
    end

    // Publish per-channel results
    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            cfg.adc_value[i] = out_q[i];
        end
    end

endmodule

// *** rtl/pdafr_cfg_if.sv ***
// Interface: stored settings and pad state between the bank and its users
`timescale 1ns/1ps
interface pdafr_cfg_if;
    logic [15:0] filt_mode;
    logic [15:0] bclk_str;
    logic [15:0] fclk_str;
    logic [15:0] mpin_str;
    logic [15:0] sdout_str;
    logic [15:0] misc_str;
    logic [11:0] bclk_master;
    logic [11:0] fclk_master;
    logic [11:0] mpin_output;
    logic [3:0][9:0] adc_value;

    modport regs (
        output filt_mode, bclk_str, fclk_str, mpin_str, sdout_str, misc_str,
        output bclk_master, fclk_master, mpin_output,
        input adc_value
    );
    modport pad (
        input bclk_str, fclk_str, mpin_str, sdout_str, misc_str,
        input bclk_master, fclk_master, mpin_output
    );
    modport flt (
        input filt_mode,
        output adc_value
    );
endinterface

// *** rtl/pdafr_pad_ctrl.sv ***
// Pad drive strength controls derived from the stored select bits
`timescale 1ns/1ps
module pdafr_pad_ctrl
    import pdafr_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    pdafr_cfg_if.pad cfg,
    output logic [11:0] bclk_hi_o,
    output logic [11:0] fclk_hi_o,
    output logic [11:0] mpin_hi_o,
    output logic [8:0] sdout_hi_o,
    output logic [6:0] misc_hi_o
);

    // Clock pads obey their select bit only while mastering the clock;
    // a slave clock pin is an input, so asking for drive makes no sense
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bclk_hi_o <= '0;
            fclk_hi_o <= '0;
        end else begin
            bclk_hi_o <= cfg.bclk_str[11:0] & cfg.bclk_master;
            fclk_hi_o <= cfg.fclk_str[11:0] & cfg.fclk_master;
        end
    end

    // Multipurpose pins only when configured as outputs
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mpin_hi_o <= '0;
        end else begin
            mpin_hi_o <= cfg.mpin_str[11:0] & cfg.mpin_output;
        end
    end

    // Data and control pads always drive, so no gating
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sdout_hi_o <= '0;
            misc_hi_o <= '0;
        end else begin
            sdout_hi_o <= cfg.sdout_str[8:0];
            misc_hi_o <= cfg.misc_str[6:0];
        end
    end

endmodule

// *** rtl/pdafr_pkg.sv ***
// Package: register map, field layout and reset values of the pad bank
package pdafr_pkg;

    // Register offsets, word addresses on the register port
    localparam logic [15:0] PDAFR_OFF_FILT_MODE = 16'hE224;
    localparam logic [15:0] PDAFR_OFF_BCLK_STR = 16'hE247;
    localparam logic [15:0] PDAFR_OFF_FCLK_STR = 16'hE248;
    localparam logic [15:0] PDAFR_OFF_MPIN_STR = 16'hE249;
    localparam logic [15:0] PDAFR_OFF_SDOUT_STR = 16'hE24A;
    localparam logic [15:0] PDAFR_OFF_MISC_STR = 16'hE24C;
    // Read-only filtered converter values, one per channel
    localparam logic [15:0] PDAFR_OFF_ADC_VAL0 = 16'hE260;
    localparam logic [15:0] PDAFR_OFF_ADC_VAL1 = 16'hE261;
    localparam logic [15:0] PDAFR_OFF_ADC_VAL2 = 16'hE262;
    localparam logic [15:0] PDAFR_OFF_ADC_VAL3 = 16'hE263;

    // Writable bit masks; everything outside reads zero
    localparam logic [15:0] PDAFR_MASK_FILT = 16'h00FF;
    localparam logic [15:0] PDAFR_MASK_12 = 16'h0FFF;
    localparam logic [15:0] PDAFR_MASK_SDOUT = 16'h01FF;
    localparam logic [15:0] PDAFR_MASK_MISC = 16'h007F;

    // Reset values: filters bypassed, all pads low strength
    localparam logic [15:0] PDAFR_RST_FILT = 16'h0000;
    localparam logic [15:0] PDAFR_RST_STR = 16'h0000;

    // Field layout of the filter mode register
    localparam int PDAFR_CH0_MODE_LSB = 6;
    localparam int PDAFR_MODE_W = 2;

    // Miscellaneous strength bit positions
    localparam int PDAFR_MISC_CTRL_CLK = 6;
    localparam int PDAFR_MISC_CTRL_LATCH = 5;
    localparam int PDAFR_MISC_ADDRESS1_DIN = 4;
    localparam int PDAFR_MISC_ADDRESS0 = 3;
    localparam int PDAFR_MISC_CTRL_DOUT = 2;
    localparam int PDAFR_MISC_SPDIF_OUT = 1;
    localparam int PDAFR_MISC_CLK_OUT = 0;

    // Hysteresis dead bands in converter LSBs
    localparam logic [9:0] PDAFR_HYST1_LSB = 10'h001;
    localparam logic [9:0] PDAFR_HYST2_LSB = 10'h003;

    // Filter modes
    typedef enum logic [1:0] {
        PDAFR_FILT_BYPASS = 2'b00,
        PDAFR_FILT_ON = 2'b01,
        PDAFR_FILT_HYST1 = 2'b10,
        PDAFR_FILT_HYST2 = 2'b11
    } pdafr_filt_mode_t;

endpackage

// *** rtl/pdafr_top.sv ***
// Top: pad drive strength and converter filter mode register bank
//
// Behaviour
// - Mode 00 bypasses, 01 filters, 10/11 add 1/2-bit hysteresis, reset 00.
// - Filter channels 0..3 sit at 7:6, 5:4, 3:2, 1:0; bits 15:8 reserved.
// - Bit clock drive: twelve bits, one per pad, only while it masters.
// - Frame clock drive: twelve bits, one per pad, only while it masters.
// - Multipurpose drive: twelve bits, one per pin, only while an output.
// - Serial output drive: nine bits at 8:0, one per output pad.
// - Misc bits 6..0: port clk, latch, a1/din, a0, dout, S/PDIF, clock out.
// - Select bit 0 asks low strength, 1 high strength; all reset to 0.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
module pdafr_top
    import pdafr_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    input wire logic [9:0] adc_sample_i,
    input wire logic [1:0] adc_chan_i,
    input wire logic adc_valid_i,
    output logic [39:0] adc_value_o,
    input wire logic [11:0] bclk_master_i,
    input wire logic [11:0] fclk_master_i,
    input wire logic [11:0] mpin_output_i,
    output logic [11:0] bitclock_pin_hi_o,
    output logic [11:0] frameclock_pin_hi_o,
    output logic [11:0] multipurpose_pin_hi_o,
    output logic [8:0] serial_data_output_pin_hi_o,
    output logic control_port_clock_pin_hi_o,
    output logic control_latch_pin_hi_o,
    output logic address1_control_data_in_pin_hi_o,
    output logic address0_pin_hi_o,
    output logic control_data_out_pin_hi_o,
    output logic spdif_output_pin_hi_o,
    output logic clock_output_pin_hi_o
);

    pdafr_cfg_if cfg ();

    logic [15:0] filt_mode_q;
    logic [15:0] bclk_str_q;
    logic [15:0] fclk_str_q;
    logic [15:0] mpin_str_q;
    logic [15:0] sdout_str_q;
    logic [15:0] misc_str_q;
    logic [15:0] rdata_d;
    logic [15:0] reg_rdata_q;
    logic [6:0] misc_hi;

    // Write strobe qualified by address
    function automatic logic wr_hit(input logic [15:0] addr,
                                    input logic wr,
                                    input logic [15:0] off);
        return wr && (addr == off);
    endfunction

    // Filter mode register; reserved upper byte never stored
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            filt_mode_q <= PDAFR_RST_FILT;
        end else if (wr_hit(reg_addr_i, reg_wr_i, PDAFR_OFF_FILT_MODE)) begin
            filt_mode_q <= reg_wdata_i & PDAFR_MASK_FILT;
        end
    end

    // Bit clock strength
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bclk_str_q <= PDAFR_RST_STR;
        end else if (wr_hit(reg_addr_i, reg_wr_i, PDAFR_OFF_BCLK_STR)) begin
            bclk_str_q <= reg_wdata_i & PDAFR_MASK_12;
        end
    end

    // Frame clock strength
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fclk_str_q <= PDAFR_RST_STR;
        end else if (wr_hit(reg_addr_i, reg_wr_i, PDAFR_OFF_FCLK_STR)) begin
            fclk_str_q <= reg_wdata_i & PDAFR_MASK_12;
        end
    end

    // Multipurpose pin strength
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mpin_str_q <= PDAFR_RST_STR;
        end else if (wr_hit(reg_addr_i, reg_wr_i, PDAFR_OFF_MPIN_STR)) begin
            mpin_str_q <= reg_wdata_i & PDAFR_MASK_12;
        end
    end

    // Serial data output strength
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sdout_str_q <= PDAFR_RST_STR;
        end else if (wr_hit(reg_addr_i, reg_wr_i, PDAFR_OFF_SDOUT_STR)) begin
            sdout_str_q <= reg_wdata_i & PDAFR_MASK_SDOUT;
        end
    end

    // Miscellaneous pad strength
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            misc_str_q <= PDAFR_RST_STR;
        end else if (wr_hit(reg_addr_i, reg_wr_i, PDAFR_OFF_MISC_STR)) begin
            misc_str_q <= reg_wdata_i & PDAFR_MASK_MISC;
        end
    end

    // Read decode; unmapped addresses answer zero rather than stall
    always_comb begin
        rdata_d = 16'h0000;
        if (reg_addr_i == PDAFR_OFF_FILT_MODE) begin
            rdata_d = filt_mode_q;
        end else if (reg_addr_i == PDAFR_OFF_BCLK_STR) begin
            rdata_d = bclk_str_q;
        end else if (reg_addr_i == PDAFR_OFF_FCLK_STR) begin
            rdata_d = fclk_str_q;
        end else if (reg_addr_i == PDAFR_OFF_MPIN_STR) begin
            rdata_d = mpin_str_q;
        end else if (reg_addr_i == PDAFR_OFF_SDOUT_STR) begin
            rdata_d = sdout_str_q;
        end else if (reg_addr_i == PDAFR_OFF_MISC_STR) begin
            rdata_d = misc_str_q;
        end else if (reg_addr_i == PDAFR_OFF_ADC_VAL0) begin
            rdata_d = {6'h00, cfg.adc_value[0]};
        end else if (reg_addr_i == PDAFR_OFF_ADC_VAL1) begin
            rdata_d = {6'h00, cfg.adc_value[1]};
        end else if (reg_addr_i == PDAFR_OFF_ADC_VAL2) begin
            rdata_d = {6'h00, cfg.adc_value[2]};
        end else if (reg_addr_i == PDAFR_OFF_ADC_VAL3) begin
            rdata_d = {6'h00, cfg.adc_value[3]};
        end
    end

    // Read data lives one cycle, then returns to zero
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_rdata_q <= 16'h0000;
        end else if (reg_rd_i) begin
            reg_rdata_q <= rdata_d;
        end else begin
            reg_rdata_q <= 16'h0000;
        end
    end

    assign reg_rdata_o = reg_rdata_q;

    // Settings and pad state into the shared carrier
    assign cfg.filt_mode = filt_mode_q;
    assign cfg.bclk_str = bclk_str_q;
    assign cfg.fclk_str = fclk_str_q;
    assign cfg.mpin_str = mpin_str_q;
    assign cfg.sdout_str = sdout_str_q;
    assign cfg.misc_str = misc_str_q;
    assign cfg.bclk_master = bclk_master_i;
    assign cfg.fclk_master = fclk_master_i;
    assign cfg.mpin_output = mpin_output_i;

    pdafr_adc_filter #(
        .CHANNELS(4)
    ) u_filter (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .sample_i(adc_sample_i),
        .chan_i(adc_chan_i),
        .valid_i(adc_valid_i),
        .cfg(cfg.flt)
    );

    assign adc_value_o = cfg.adc_value;

    pdafr_pad_ctrl u_pads (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .cfg(cfg.pad),
        .bclk_hi_o(bitclock_pin_hi_o),
        .fclk_hi_o(frameclock_pin_hi_o),
        .mpin_hi_o(multipurpose_pin_hi_o),
        .sdout_hi_o(serial_data_output_pin_hi_o),
        .misc_hi_o(misc_hi)
    );

    // Split the misc group into its named pads
    assign control_port_clock_pin_hi_o = misc_hi[PDAFR_MISC_CTRL_CLK];
    assign control_latch_pin_hi_o = misc_hi[PDAFR_MISC_CTRL_LATCH];
    assign address1_control_data_in_pin_hi_o =
        misc_hi[PDAFR_MISC_ADDRESS1_DIN];
    assign address0_pin_hi_o = misc_hi[PDAFR_MISC_ADDRESS0];
    assign control_data_out_pin_hi_o = misc_hi[PDAFR_MISC_CTRL_DOUT];
    assign spdif_output_pin_hi_o = misc_hi[PDAFR_MISC_SPDIF_OUT];
    assign clock_output_pin_hi_o = misc_hi[PDAFR_MISC_CLK_OUT];

endmodule

// *** tb/pdafr_top_monitor.sv ***
// Checker: register port and pad strength behaviour of the bank
`timescale 1ns/1ps
module pdafr_top_monitor
    import pdafr_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic [11:0] bclk_master_i,
    input wire logic [11:0] fclk_master_i,
    input wire logic [11:0] mpin_output_i,
    input wire logic [11:0] bitclock_pin_hi_o,
    input wire logic [11:0] frameclock_pin_hi_o,
    input wire logic [11:0] multipurpose_pin_hi_o,
    input wire logic [8:0] serial_data_output_pin_hi_o,
    input wire logic control_port_clock_pin_hi_o,
    input wire logic control_latch_pin_hi_o,
    input wire logic address1_control_data_in_pin_hi_o,
    input wire logic address0_pin_hi_o,
    input wire logic control_data_out_pin_hi_o,
    input wire logic spdif_output_pin_hi_o,
    input wire logic clock_output_pin_hi_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);
    logic [6:0] misc_w;
    // Misc pads gathered in register bit order
    assign misc_w = {control_port_clock_pin_hi_o, control_latch_pin_hi_o,
        address1_control_data_in_pin_hi_o, address0_pin_hi_o,
        control_data_out_pin_hi_o, spdif_output_pin_hi_o,
        clock_output_pin_hi_o};
    sequence s_wr(logic [15:0] a);
        reg_wr_i && reg_addr_i == a;
    endsequence
    sequence s_rd(logic [15:0] a);
        reg_rd_i && reg_addr_i == a;
    endsequence
    rd_idle_zero_a: assert property (
        !reg_rd_i |=> reg_rdata_o == 16'h0000)
        else $error("read data not zero outside a read");
    bclk_write_a: assert property (s_wr(PDAFR_OFF_BCLK_STR) |=> ##1
        {4'h0, bitclock_pin_hi_o} ==
        ($past(reg_wdata_i, 2) & {4'h0, $past(bclk_master_i)}))
        else $error("bit clock strength wrong after write");
    fclk_write_a: assert property (s_wr(PDAFR_OFF_FCLK_STR) |=> ##1
        {4'h0, frameclock_pin_hi_o} ==
        ($past(reg_wdata_i, 2) & {4'h0, $past(fclk_master_i)}))
        else $error("frame clock strength wrong after write");
    mpin_write_a: assert property (s_wr(PDAFR_OFF_MPIN_STR) |=> ##1
        {4'h0, multipurpose_pin_hi_o} ==
        ($past(reg_wdata_i, 2) & {4'h0, $past(mpin_output_i)}))
        else $error("multipurpose strength wrong after write");
    sdout_write_a: assert property (s_wr(PDAFR_OFF_SDOUT_STR) |=> ##1
        {7'h00, serial_data_output_pin_hi_o} ==
        ($past(reg_wdata_i, 2) & 16'h01FF))
        else $error("serial output strength wrong after write");
    misc_map_a: assert property (s_wr(PDAFR_OFF_MISC_STR) |=> ##1
        {9'h000, misc_w} == ($past(reg_wdata_i, 2) & 16'h007F))
        else $error("misc strength bits misplaced");
    gate_only_a: assert property (1'b1 |=>
        (bitclock_pin_hi_o & ~$past(bclk_master_i)) == 12'h000 &&
        (frameclock_pin_hi_o & ~$past(fclk_master_i)) == 12'h000 &&
        (multipurpose_pin_hi_o & ~$past(mpin_output_i)) == 12'h000)
        else $error("high strength on a pad not driving");
    mode_resv_a: assert property (
        s_rd(PDAFR_OFF_FILT_MODE) |=> reg_rdata_o[15:8] == 8'h00)
        else $error("filter mode upper byte not zero");
    twelve_resv_a: assert property (reg_rd_i &&
        reg_addr_i inside {16'hE247, 16'hE248, 16'hE249} |=>
        reg_rdata_o[15:12] == 4'h0)
        else $error("strength reserved bits not zero");
    unmapped_rd_a: assert property (
        s_rd(16'hE24B) |=> reg_rdata_o == 16'h0000)
        else $error("unmapped read not zero");
endmodule
bind pdafr_top pdafr_top_monitor u_mon (.clk_sys_i, .arst_n_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .bclk_master_i,
    .fclk_master_i, .mpin_output_i, .bitclock_pin_hi_o, .frameclock_pin_hi_o,
    .multipurpose_pin_hi_o, .serial_data_output_pin_hi_o,
    .control_port_clock_pin_hi_o, .control_latch_pin_hi_o,
    .address1_control_data_in_pin_hi_o, .address0_pin_hi_o,
    .control_data_out_pin_hi_o, .spdif_output_pin_hi_o,
    .clock_output_pin_hi_o);

// *** tb/pdafr_top_tb.sv ***
// Testbench: registers, pad gating and converter filter of the bank
`timescale 1ns/1ps
module pdafr_top_tb
    import pdafr_pkg::*;
;
    logic clk_sys_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [15:0] reg_addr_i = 16'h0000;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [15:0] reg_rdata_o;
    logic [9:0] adc_sample_i = 10'h000;
    logic [1:0] adc_chan_i = 2'h0;
    logic adc_valid_i = 1'b0;
    logic [39:0] adc_value_o;
    logic [11:0] bclk_master_i = 12'h000;
    logic [11:0] fclk_master_i = 12'h000;
    logic [11:0] mpin_output_i = 12'h000;
    logic [11:0] bc_o, fc_o, mpin_o;
    logic [8:0] sd_o;
    logic [6:0] misc_o;
    int err_count = 0;
    int compares = 0;
    int acc[4];
    int outv[4];
    logic [15:0] filt_q;
    logic [15:0] offs[6] = '{16'hE224, 16'hE247, 16'hE248, 16'hE249,
        16'hE24A, 16'hE24C};
    logic [15:0] msk[6] = '{16'h00FF, 16'h0FFF, 16'h0FFF, 16'h0FFF,
        16'h01FF, 16'h007F};
    // 250 MHz core clock
    always #2 clk_sys_i = ~clk_sys_i;
    pdafr_top u_dut (.clk_sys_i, .arst_n_i, .reg_addr_i, .reg_wdata_i,
        .reg_wr_i, .reg_rd_i, .reg_rdata_o, .adc_sample_i, .adc_chan_i,
        .adc_valid_i, .adc_value_o, .bclk_master_i, .fclk_master_i,
        .mpin_output_i, .bitclock_pin_hi_o(bc_o), .frameclock_pin_hi_o(fc_o),
        .multipurpose_pin_hi_o(mpin_o), .serial_data_output_pin_hi_o(sd_o),
        .control_port_clock_pin_hi_o(misc_o[6]),
        .control_latch_pin_hi_o(misc_o[5]),
        .address1_control_data_in_pin_hi_o(misc_o[4]),
        .address0_pin_hi_o(misc_o[3]),
        .control_data_out_pin_hi_o(misc_o[2]),
        .spdif_output_pin_hi_o(misc_o[1]),
        .clock_output_pin_hi_o(misc_o[0]));
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask
    // Read data is only valid in the cycle after the strobe
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        @(negedge clk_sys_i);
        chk(64'(reg_rdata_o), 64'(e));
    endtask
    // Pad outputs lag the register by one more edge
    task automatic pads(input logic [63:0] e);
        repeat (2) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        chk(64'({bc_o, fc_o, mpin_o, sd_o, misc_o}), e);
    endtask
    task automatic do_reset(input int n);
        @(posedge clk_sys_i);
        arst_n_i <= 1'b0;
        repeat (n) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        acc = '{0, 0, 0, 0};
        outv = '{0, 0, 0, 0};
    endtask
    task automatic t_defaults();
        for (int i = 0; i < 6; i++) begin
            rd(offs[i], 16'h0000);
        end
        pads(64'h0);
    endtask
    task automatic t_rw();
        for (int i = 0; i < 6; i++) begin
            wr(offs[i], 16'hFFFF);
            rd(offs[i], msk[i]);
            wr(offs[i], 16'hA5A5);
            rd(offs[i], msk[i] & 16'hA5A5);
        end
        wr(16'hE24B, 16'hFFFF);
        rd(16'hE24B, 16'h0000);
    endtask
    task automatic t_pads();
        @(posedge clk_sys_i);
        bclk_master_i <= 12'h0F0;
        fclk_master_i <= 12'hA5A;
        mpin_output_i <= 12'h3C3;
        wr(PDAFR_OFF_BCLK_STR, 16'hFFFF);
        wr(PDAFR_OFF_FCLK_STR, 16'hF0F0);
        wr(PDAFR_OFF_MPIN_STR, 16'hFFFF);
        wr(PDAFR_OFF_SDOUT_STR, 16'hFF5A);
        wr(PDAFR_OFF_MISC_STR, 16'h0000);
        pads({12'h0F0, 12'h050, 12'h3C3, 9'h15A, 7'h00});
        @(posedge clk_sys_i);
        bclk_master_i <= 12'hF0F;
        fclk_master_i <= 12'h5A5;
        mpin_output_i <= 12'hC3C;
        pads({12'hF0F, 12'h0A0, 12'hC3C, 9'h15A, 7'h00});
        for (int n = 0; n < 7; n++) begin
            wr(PDAFR_OFF_MISC_STR, 16'h0001 << n);
            pads({12'hF0F, 12'h0A0, 12'hC3C, 9'h15A, 7'(1 << n)});
        end
        wr(PDAFR_OFF_MISC_STR, 16'hFF80);
        rd(PDAFR_OFF_MISC_STR, 16'h0000);
        wr(PDAFR_OFF_SDOUT_STR, PDAFR_RST_STR);
        pads({12'hF0F, 12'h0A0, 12'hC3C, 9'h000, 7'h00});
    endtask
    // Reference filter: leaky sum, quarter average, dead band per mode
    task automatic sample(input int ch, input int s);
        int avg, m, d;
        m = (filt_q >> (6 - 2 * ch)) & 3;
        acc[ch] = acc[ch] - acc[ch] / 4 + s;
        avg = acc[ch] / 4;
        d = (avg > outv[ch]) ? avg - outv[ch] : outv[ch] - avg;
        if (m == 0)
            outv[ch] = s;
        else if (m == 1 || (m == 2 && d > 1) || (m == 3 && d > 3))
            outv[ch] = avg;
        @(posedge clk_sys_i);
        adc_sample_i <= 10'(s);
        adc_chan_i <= 2'(ch);
        adc_valid_i <= 1'b1;
        @(posedge clk_sys_i);
        adc_valid_i <= 1'b0;
        @(negedge clk_sys_i);
        chk(64'(adc_value_o[10 * ch +: 10]), 64'(outv[ch]));
        rd(PDAFR_OFF_ADC_VAL0 + 16'(ch), 16'(outv[ch]));
    endtask
    task automatic t_filter();
        for (int r = 0; r < 4; r++) begin
            filt_q = 16'h0000;
            for (int c = 0; c < 4; c++) begin
                filt_q = filt_q | 16'(((r + c) % 4) << (6 - 2 * c));
            end
            wr(PDAFR_OFF_FILT_MODE, filt_q);
            for (int k = 0; k < 6; k++) begin
                for (int c = 0; c < 4; c++) begin
                    sample(c, 300 + c * 50 + (k % 2) * (2 + k));
                end
            end
        end
    endtask
    task automatic end_sim();
        if (err_count == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Main sequence, with a second reset in mid-run
    initial begin
        do_reset(20);
        t_defaults();
        t_rw();
        t_pads();
        t_filter();
        do_reset(3);
        t_defaults();
        end_sim();
    end
    // Watchdog, far beyond the several hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        err_count++;
        end_sim();
    end
endmodule
